// file: verilog/spw_cfg.svh
`ifndef SPW_CFG_SVH
`define SPW_CFG_SVH

// sampling clock
`define SPW_CLK_NS        50
// link times, in microseconds
`define SPW_SU_US         100
`define SPW_SD_US         2500
`define SPW_HOLDA_MIN_US  50
`define SPW_HOLDA_MAX_US  150
`define SPW_HOLDD_MIN_US  50
`define SPW_STBY_US       10000
`define SPW_PULSE_US      5
`define SPW_HOST_HOLDA_US 100
`define SPW_HOST_HOLDD_US 60
`define SPW_HOST_WAKE_US  120
// least times round up, longest times round down
`define SPW_UP(us)        (((us) * 1000 + `SPW_CLK_NS - 1) / `SPW_CLK_NS)
`define SPW_DN(us)        (((us) * 1000) / `SPW_CLK_NS)
`define SPW_SU_CYC        `SPW_UP(`SPW_SU_US)
`define SPW_SD_CYC        `SPW_UP(`SPW_SD_US)
`define SPW_HOLDA_MIN_CYC `SPW_UP(`SPW_HOLDA_MIN_US)
`define SPW_HOLDA_MAX_CYC `SPW_DN(`SPW_HOLDA_MAX_US)
`define SPW_HOLDD_MIN_CYC `SPW_UP(`SPW_HOLDD_MIN_US)
`define SPW_STBY_CYC      `SPW_UP(`SPW_STBY_US)
`define SPW_PULSE_CYC     `SPW_UP(`SPW_PULSE_US)
`define SPW_HOST_HOLDA_CYC `SPW_UP(`SPW_HOST_HOLDA_US)
`define SPW_HOST_HOLDD_CYC `SPW_UP(`SPW_HOST_HOLDD_US)
`define SPW_HOST_WAKE_CYC `SPW_UP(`SPW_HOST_WAKE_US)
// command fields
`define SPW_ADDR_W        5
`define SPW_DATA_W        6
`define SPW_CNT_W         7
`define SPW_ADDR_EDGES    32
`define SPW_DATA_EDGES    64

`endif

// file: verilog/spw_pkg.sv
`include "spw_cfg.svh"

package spw_pkg;
  typedef logic [`SPW_ADDR_W-1:0] spw_addr_type;
  typedef logic [`SPW_DATA_W-1:0] spw_data_type;
  typedef logic [`SPW_CNT_W-1:0]  spw_cnt_type;
  typedef enum {SPW_RX_ADDR, SPW_RX_DATA} spw_rx_state_type;
  typedef enum {SPW_TX_OFF, SPW_TX_WAKE, SPW_TX_IDLE, SPW_TX_LOW, SPW_TX_HIGH} spw_tx_state_type;
endpackage

// file: verilog/spw_if.sv
`timescale 1ns/1ns

interface spw_if;
  logic single_wire_pin;
  modport host (output single_wire_pin);
  modport dev  (input  single_wire_pin);
endinterface

// file: verilog/spw_dev.sv
// Behaviour
// [RULE_01] write only, up to 32 registers
// [RULE_02] address train, hold, data train, hold
// [RULE_03] enable after high beyond setup time
// [RULE_04] disable after low beyond shutdown time
// [RULE_05] address is first-train edges minus one
// [RULE_06] valid count plus address hold captures address
// [RULE_07] short high keeps counting address edges
// [RULE_08] address count over 31 discards command
// [RULE_09] address hold over maximum abandons command
// [RULE_10] data is second-train edges minus one
// [RULE_11] data accepted after data hold only
// [RULE_12] data count over 63 discards write
// [RULE_13] after data hold expect address, no maximum
// [RULE_14] host resends address before every data
// [RULE_15] pairs need only minimum data hold apart
// [RULE_16] ten millisecond high returns to standby
// [RULE_17] non-uniform pulse widths still decode correctly
// [RULE_18] host keeps high pulses below address hold
// [RULE_19] shutdown returns registers to defaults
// [RULE_20] no readback path exists
// [RULE_21] intervals measured by sampled cycle counts
// [RULE_22] accepted write is one-cycle address/data strobe
`timescale 1ns/1ns
`include "spw_cfg.svh"

module spw_dev #(
  parameter int SU_CYC        = `SPW_SU_CYC,
  parameter int SD_CYC        = `SPW_SD_CYC,
  parameter int HOLDA_MIN_CYC = `SPW_HOLDA_MIN_CYC,
  parameter int HOLDA_MAX_CYC = `SPW_HOLDA_MAX_CYC,
  parameter int HOLDD_MIN_CYC = `SPW_HOLDD_MIN_CYC,
  parameter int STBY_CYC      = `SPW_STBY_CYC
) (
  // clock, reset, enable
  input  wire logic            ref_clk_in,
  input  wire logic            rst_n_in,
  input  wire logic            ce_in,
  // link
  spw_if.dev                   link_in,
  // register file side
  output logic                 wr_strobe_out,
  output spw_pkg::spw_addr_type wr_addr_out,
  output spw_pkg::spw_data_type wr_data_out,
  output logic                 regs_default_out,
  output logic                 cmd_drop_out,
  // device state
  output logic                 enabled_out,
  output logic                 standby_out
);

  localparam int HW = $clog2(STBY_CYC + 1);
  localparam int LW = $clog2(SD_CYC + 1);
  localparam logic [HW-1:0] SU_C        = HW'(SU_CYC);
  localparam logic [HW-1:0] HOLDA_MIN_C = HW'(HOLDA_MIN_CYC);
  localparam logic [HW-1:0] HOLDA_MAX_C = HW'(HOLDA_MAX_CYC);
  localparam logic [HW-1:0] HOLDD_MIN_C = HW'(HOLDD_MIN_CYC);
  localparam logic [HW-1:0] STBY_C      = HW'(STBY_CYC);
  localparam logic [LW-1:0] SD_C        = LW'(SD_CYC);
  localparam spw_pkg::spw_cnt_type ADDR_LIM = `SPW_CNT_W'(`SPW_ADDR_EDGES);
  localparam spw_pkg::spw_cnt_type DATA_LIM = `SPW_CNT_W'(`SPW_DATA_EDGES);
  localparam spw_pkg::spw_cnt_type CNT_ONE  = `SPW_CNT_W'(1);

  generate
    if (SU_CYC < 1 || SD_CYC < 1 || HOLDA_MIN_CYC < 1 || HOLDA_MIN_CYC >= HOLDA_MAX_CYC ||
        HOLDA_MAX_CYC >= STBY_CYC || HOLDD_MIN_CYC < 1 || HOLDD_MIN_CYC >= STBY_CYC ||
        SU_CYC >= STBY_CYC)
    begin : g_bad_params
      $error("spw_dev: timing counts out of order");
    end
  endgenerate

  logic                      line;
  logic                      rise;
  logic                      line_q_ff;
  logic                      nxt_line_q;
  logic [HW-1:0]             hi_cnt_ff;
  logic [HW-1:0]             nxt_hi_cnt;
  logic [LW-1:0]             lo_cnt_ff;
  logic [LW-1:0]             nxt_lo_cnt;
  spw_pkg::spw_rx_state_type state_ff;
  spw_pkg::spw_rx_state_type nxt_state;
  spw_pkg::spw_cnt_type      cnt_ff;
  spw_pkg::spw_cnt_type      nxt_cnt;
  logic                      ovf_ff;
  logic                      nxt_ovf;
  logic                      en_ff;
  logic                      nxt_en;
  logic                      stby_ff;
  logic                      nxt_stby;
  logic                      strobe_ff;
  logic                      nxt_strobe;
  logic                      dflt_ff;
  logic                      nxt_dflt;
  logic                      drop_ff;
  logic                      nxt_drop;
  spw_pkg::spw_addr_type     addr_ff;
  spw_pkg::spw_addr_type     nxt_addr;
  spw_pkg::spw_data_type     data_ff;
  spw_pkg::spw_data_type     nxt_data;

  assign line = link_in.single_wire_pin;
  assign rise = line & ~line_q_ff;

  // interval timers on the sampling clock
  always_comb
  begin
    nxt_line_q = line;
    nxt_hi_cnt = '0;
    nxt_lo_cnt = '0;
    if (line)
    begin
      nxt_hi_cnt = (hi_cnt_ff == STBY_C) ? hi_cnt_ff : hi_cnt_ff + 1'b1; // see [RULE_21]
    end
    else
    begin
      nxt_lo_cnt = (lo_cnt_ff == SD_C) ? lo_cnt_ff : lo_cnt_ff + 1'b1; // see [RULE_21]
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      line_q_ff <= 1'b0;
      hi_cnt_ff <= '0;
      lo_cnt_ff <= '0;
    end
    else if (ce_in)
    begin
      line_q_ff <= nxt_line_q;
      hi_cnt_ff <= nxt_hi_cnt;
      lo_cnt_ff <= nxt_lo_cnt;
    end
  end

  // command decoder
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_ovf    = ovf_ff;
    nxt_en     = en_ff;
    nxt_stby   = stby_ff & line;
    nxt_addr   = addr_ff;
    nxt_data   = data_ff;
    nxt_strobe = 1'b0;
    nxt_dflt   = 1'b0;
    nxt_drop   = 1'b0;
    if (!en_ff)
    begin
      nxt_state = spw_pkg::SPW_RX_ADDR;
      nxt_cnt   = '0;
      nxt_ovf   = 1'b0;
      nxt_stby  = 1'b0;
      if (hi_cnt_ff == SU_C)
      begin
        nxt_en = 1'b1; // see [RULE_03]
      end
    end
    else if (lo_cnt_ff == SD_C)
    begin
      nxt_en    = 1'b0; // see [RULE_04]
      nxt_dflt  = 1'b1; // see [RULE_19]
      nxt_state = spw_pkg::SPW_RX_ADDR;
      nxt_cnt   = '0;
      nxt_ovf   = 1'b0;
    end
    else if (hi_cnt_ff == STBY_C)
    begin
      nxt_stby  = 1'b1; // see [RULE_16]
      nxt_state = spw_pkg::SPW_RX_ADDR;
      nxt_cnt   = '0;
      nxt_ovf   = 1'b0;
    end
    else
    begin
      case (state_ff)
        spw_pkg::SPW_RX_ADDR:
        begin
          if (rise)
          begin
            // edges may come at any spacing below the hold time
            if (cnt_ff == ADDR_LIM)
            begin
              nxt_ovf = 1'b1; // see [RULE_08]
            end
            else
            begin
              nxt_cnt = cnt_ff + CNT_ONE; // see [RULE_07] see [RULE_17]
            end
          end
          else if (cnt_ff != '0 && hi_cnt_ff == HOLDA_MIN_C)
          begin
            nxt_cnt = '0;
            nxt_ovf = 1'b0;
            if (ovf_ff)
            begin
              nxt_drop = 1'b1; // see [RULE_08]
            end
            else
            begin
              nxt_addr  = `SPW_ADDR_W'(cnt_ff - CNT_ONE); // see [RULE_05] see [RULE_01]
              nxt_state = spw_pkg::SPW_RX_DATA; // see [RULE_06] see [RULE_02]
            end
          end
        end
        spw_pkg::SPW_RX_DATA:
        begin
          if (rise)
          begin
            if (cnt_ff == DATA_LIM)
            begin
              nxt_ovf = 1'b1; // see [RULE_12]
            end
            else
            begin
              nxt_cnt = cnt_ff + CNT_ONE; // see [RULE_11] see [RULE_17]
            end
          end
          else if (cnt_ff == '0 && hi_cnt_ff == HOLDA_MAX_C)
          begin
            nxt_drop  = 1'b1; // see [RULE_09]
            nxt_state = spw_pkg::SPW_RX_ADDR;
          end
          else if (cnt_ff != '0 && hi_cnt_ff == HOLDD_MIN_C)
          begin
            nxt_cnt   = '0;
            nxt_ovf   = 1'b0;
            nxt_state = spw_pkg::SPW_RX_ADDR; // see [RULE_13] see [RULE_15]
            if (ovf_ff)
            begin
              nxt_drop = 1'b1; // see [RULE_12]
            end
            else
            begin
              nxt_data   = `SPW_DATA_W'(cnt_ff - CNT_ONE); // see [RULE_10]
              nxt_strobe = 1'b1; // see [RULE_02] see [RULE_22]
            end
          end
        end
        default:
        begin
          nxt_state = spw_pkg::SPW_RX_ADDR;
          nxt_cnt   = '0;
          nxt_ovf   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_ff  <= spw_pkg::SPW_RX_ADDR;
      cnt_ff    <= '0;
      ovf_ff    <= 1'b0;
      en_ff     <= 1'b0;
      stby_ff   <= 1'b0;
      addr_ff   <= '0;
      data_ff   <= '0;
      strobe_ff <= 1'b0;
      dflt_ff   <= 1'b0;
      drop_ff   <= 1'b0;
    end
    else if (ce_in)
    begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      ovf_ff    <= nxt_ovf;
      en_ff     <= nxt_en;
      stby_ff   <= nxt_stby;
      addr_ff   <= nxt_addr;
      data_ff   <= nxt_data;
      strobe_ff <= nxt_strobe;
      dflt_ff   <= nxt_dflt;
      drop_ff   <= nxt_drop;
    end
  end

  // outputs only; the link has no return path
  assign wr_strobe_out    = strobe_ff; // see [RULE_20]
  assign wr_addr_out      = addr_ff;
  assign wr_data_out      = data_ff;
  assign regs_default_out = dflt_ff;
  assign cmd_drop_out     = drop_ff;
  assign enabled_out      = en_ff;
  assign standby_out      = stby_ff;

endmodule

// file: verilog/spw_host.sv
`timescale 1ns/1ns
`include "spw_cfg.svh"

module spw_host #(
  parameter int PULSE_CYC = `SPW_PULSE_CYC,
  parameter int HOLDA_CYC = `SPW_HOST_HOLDA_CYC,
  parameter int HOLDD_CYC = `SPW_HOST_HOLDD_CYC,
  parameter int WAKE_CYC  = `SPW_HOST_WAKE_CYC
) (
  // clock, reset, enable
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  // user side
  input  wire logic             dev_on_in,
  input  wire logic             cmd_valid_in,
  input  spw_pkg::spw_addr_type cmd_addr_in,
  input  spw_pkg::spw_data_type cmd_data_in,
  output logic                  cmd_ready_out,
  // link
  spw_if.host                   link_out
);

  localparam int TMAX = (WAKE_CYC > HOLDA_CYC) ? WAKE_CYC : HOLDA_CYC;
  localparam int TW   = $clog2(TMAX + 1);
  localparam logic [TW-1:0] PULSE_END = TW'(PULSE_CYC - 1);
  localparam logic [TW-1:0] HOLDA_END = TW'(HOLDA_CYC - 1);
  localparam logic [TW-1:0] HOLDD_END = TW'(HOLDD_CYC - 1);
  localparam logic [TW-1:0] WAKE_END  = TW'(WAKE_CYC - 1);

  generate
    if (PULSE_CYC < 1 || PULSE_CYC >= HOLDD_CYC || PULSE_CYC >= HOLDA_CYC || WAKE_CYC < 1 || HOLDD_CYC > TMAX)
    begin : g_bad_params
      $error("spw_host: pulse must be shorter than both holds");
    end
  endgenerate

  spw_pkg::spw_tx_state_type st_ff;
  spw_pkg::spw_tx_state_type nxt_st;
  logic [TW-1:0]             tmr_ff;
  logic [TW-1:0]             nxt_tmr;
  spw_pkg::spw_cnt_type      left_ff;
  spw_pkg::spw_cnt_type      nxt_left;
  logic                      data_ph_ff;
  logic                      nxt_data_ph;
  spw_pkg::spw_data_type     data_ff;
  spw_pkg::spw_data_type     nxt_data;
  logic                      line_ff;
  logic                      nxt_line;
  logic [TW-1:0]             high_end;

  assign cmd_ready_out = (st_ff == spw_pkg::SPW_TX_IDLE) & dev_on_in;
  assign high_end = (left_ff != '0) ? PULSE_END : (data_ph_ff ? HOLDD_END : HOLDA_END);

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_tmr     = tmr_ff + 1'b1;
    nxt_left    = left_ff;
    nxt_data_ph = data_ph_ff;
    nxt_data    = data_ff;
    nxt_line    = line_ff;
    if (!dev_on_in)
    begin
      nxt_st   = spw_pkg::SPW_TX_OFF;
      nxt_line = 1'b0;
      nxt_tmr  = '0;
    end
    else
    begin
      case (st_ff)
        spw_pkg::SPW_TX_OFF:
        begin
          nxt_st   = spw_pkg::SPW_TX_WAKE;
          nxt_line = 1'b1;
          nxt_tmr  = '0;
        end
        spw_pkg::SPW_TX_WAKE:
        begin
          if (tmr_ff == WAKE_END)
          begin
            nxt_st = spw_pkg::SPW_TX_IDLE;
          end
        end
        spw_pkg::SPW_TX_IDLE:
        begin
          nxt_tmr = '0;
          if (cmd_valid_in)
          begin
            // every data train is preceded by its own address train
            nxt_left    = {2'b00, cmd_addr_in} + `SPW_CNT_W'(1); // see [RULE_14]
            nxt_data    = cmd_data_in;
            nxt_data_ph = 1'b0;
            nxt_st      = spw_pkg::SPW_TX_LOW;
            nxt_line    = 1'b0;
          end
        end
        spw_pkg::SPW_TX_LOW:
        begin
          if (tmr_ff == PULSE_END)
          begin
            nxt_st   = spw_pkg::SPW_TX_HIGH;
            nxt_line = 1'b1;
            nxt_tmr  = '0;
            nxt_left = left_ff - `SPW_CNT_W'(1);
          end
        end
        spw_pkg::SPW_TX_HIGH:
        begin
          // short highs inside a train, holds between windows at its end
          if (tmr_ff == high_end) // see [RULE_18] see [RULE_15]
          begin
            nxt_tmr = '0;
            if (left_ff != '0)
            begin
              nxt_st   = spw_pkg::SPW_TX_LOW;
              nxt_line = 1'b0;
            end
            else if (!data_ph_ff)
            begin
              nxt_data_ph = 1'b1;
              nxt_left    = {1'b0, data_ff} + `SPW_CNT_W'(1); // see [RULE_02]
              nxt_st      = spw_pkg::SPW_TX_LOW;
              nxt_line    = 1'b0;
            end
            else
            begin
              nxt_st = spw_pkg::SPW_TX_IDLE;
            end
          end
        end
        default:
        begin
          nxt_st   = spw_pkg::SPW_TX_OFF;
          nxt_line = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      st_ff      <= spw_pkg::SPW_TX_OFF;
      tmr_ff     <= '0;
      left_ff    <= '0;
      data_ph_ff <= 1'b0;
      data_ff    <= '0;
      line_ff    <= 1'b0;
    end
    else if (ce_in)
    begin
      st_ff      <= nxt_st;
      tmr_ff     <= nxt_tmr;
      left_ff    <= nxt_left;
      data_ph_ff <= nxt_data_ph;
      data_ff    <= nxt_data;
      line_ff    <= nxt_line;
    end
  end

  assign link_out.single_wire_pin = line_ff;

endmodule

// file: dv/spw_monitor.sv
`timescale 1ns/1ns

module spw_monitor #(
  parameter int SU_CYC        = 20,
  parameter int SD_CYC        = 200,
  parameter int HOLDA_MIN_CYC = 40,
  parameter int HOLDD_MIN_CYC = 40,
  parameter int STBY_CYC      = 300
) (
  // clock, reset, enable
  input wire logic                  ref_clk_in,
  input wire logic                  rst_n_in,
  input wire logic                  ce_in,
  // link and device outputs
  input wire logic                  single_wire_pin,
  input wire logic                  wr_strobe_out,
  input wire spw_pkg::spw_addr_type wr_addr_out,
  input wire spw_pkg::spw_data_type wr_data_out,
  input wire logic                  regs_default_out,
  input wire logic                  cmd_drop_out,
  input wire logic                  enabled_out,
  input wire logic                  standby_out
);
  // saturating run lengths of the sampled line
  logic [10:0] hi_ff;
  logic [10:0] lo_ff;
  logic [10:0] nxt_hi;
  logic [10:0] nxt_lo;

  always_comb
  begin
    nxt_hi = 11'h000;
    nxt_lo = 11'h000;
    if (single_wire_pin)
      nxt_hi = hi_ff + ((hi_ff != 11'h7FF) ? 11'h001 : 11'h000);
    else
      nxt_lo = lo_ff + ((lo_ff != 11'h7FF) ? 11'h001 : 11'h000);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      hi_ff <= 11'h000;
      lo_ff <= 11'h000;
    end
    else if (ce_in)
    begin
      hi_ff <= nxt_hi;
      lo_ff <= nxt_lo;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in || !ce_in);

  strobe_pulse_a: assert property (wr_strobe_out |=> !wr_strobe_out)
    else $error("write strobe longer than one cycle");
  strobe_hold_a: assert property (wr_strobe_out |-> hi_ff >= HOLDD_MIN_CYC && hi_ff <= HOLDD_MIN_CYC + 4)
    else $error("write strobe outside data hold moment");
  addr_capture_a: assert property ($changed(wr_addr_out) && enabled_out && !standby_out |-> hi_ff >= HOLDA_MIN_CYC)
    else $error("address changed before address hold");
  data_update_a: assert property ($changed(wr_data_out) && enabled_out |-> wr_strobe_out)
    else $error("data changed without write strobe");
  enable_setup_a: assert property ($rose(enabled_out) |-> hi_ff >= SU_CYC && hi_ff <= SU_CYC + 5)
    else $error("enable not tied to setup time");
  shutdown_time_a: assert property ($fell(enabled_out) |-> lo_ff >= SD_CYC && lo_ff <= SD_CYC + 5)
    else $error("disable not tied to shutdown time");
  regs_default_a: assert property (regs_default_out |-> !enabled_out && $past(enabled_out) && lo_ff >= SD_CYC)
    else $error("default request without shutdown");
  standby_entry_a: assert property ($rose(standby_out) |-> hi_ff >= STBY_CYC && hi_ff <= STBY_CYC + 5)
    else $error("standby not tied to idle time");
  standby_exit_a: assert property (standby_out && !single_wire_pin |-> ##[1:3] !standby_out)
    else $error("standby held while line low");
  drop_pulse_a: assert property (cmd_drop_out |-> !wr_strobe_out ##1 !cmd_drop_out)
    else $error("drop pulse malformed or with strobe");
  strobe_enabled_a: assert property (wr_strobe_out |-> enabled_out && !standby_out)
    else $error("write strobe while not enabled");
endmodule

// file: dv/pulse_count_write_port_tb_top.sv
`timescale 1ns/1ns

module pulse_count_write_port_tb_top;
  localparam int SU = 20, SD = 200, HAMIN = 40, HAMAX = 80, HDMIN = 40, STBY = 300;
  logic                  clk;
  logic                  rst_n;
  logic                  ce;
  logic                  dev_on;
  logic                  cmd_valid;
  spw_pkg::spw_addr_type cmd_addr;
  spw_pkg::spw_data_type cmd_data;
  logic                  cmd_ready;
  logic                  drv_pin;
  logic                  prev_pin;
  logic                  stb [2];
  spw_pkg::spw_addr_type adr [2];
  spw_pkg::spw_data_type dat [2];
  logic                  dfl [2];
  logic                  drp [2];
  logic                  en [2];
  logic                  sby [2];
  logic [11:0]           q [2][$];
  logic [11:0]           falls;
  logic [11:0]           dflt_cnt;
  int                    errors;
  int                    compares;
  int                    cyc;

  spw_if link [2] ();
  // second link is driven raw by the bench
  assign link[1].single_wire_pin = drv_pin;

  spw_host #(.PULSE_CYC(4), .HOLDA_CYC(60), .HOLDD_CYC(50), .WAKE_CYC(30)) spw_host_inst (
    .ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .dev_on_in(dev_on), .cmd_valid_in(cmd_valid),
    .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .link_out(link[0]));

  for (genvar i = 0; i < 2; i++)
  begin : dv
    spw_dev #(.SU_CYC(SU), .SD_CYC(SD), .HOLDA_MIN_CYC(HAMIN), .HOLDA_MAX_CYC(HAMAX), .HOLDD_MIN_CYC(HDMIN),
      .STBY_CYC(STBY)) spw_dev_inst (
      .ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .link_in(link[i]), .wr_strobe_out(stb[i]),
      .wr_addr_out(adr[i]), .wr_data_out(dat[i]), .regs_default_out(dfl[i]), .cmd_drop_out(drp[i]),
      .enabled_out(en[i]), .standby_out(sby[i]));
  end

  spw_monitor #(.SU_CYC(SU), .SD_CYC(SD), .HOLDA_MIN_CYC(HAMIN), .HOLDD_MIN_CYC(HDMIN), .STBY_CYC(STBY))
    spw_monitor_inst (
    .ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .single_wire_pin(link[0].single_wire_pin),
    .wr_strobe_out(stb[0]), .wr_addr_out(adr[0]), .wr_data_out(dat[0]), .regs_default_out(dfl[0]),
    .cmd_drop_out(drp[0]), .enabled_out(en[0]), .standby_out(sby[0]));

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // oldest note against each strobe or drop; empty queue forces a mismatch
  task automatic take(input int i);
    logic [11:0] e;
    e = (q[i].size() > 0) ? q[i].pop_front() : {~drp[i], 11'h7FF};
    check({drp[i], 11'h000}, {e[11], 11'h000});
    if (e[11] === 1'b0)
      check({1'b0, adr[i], dat[i]}, e);
  endtask

  task automatic send(input spw_pkg::spw_addr_type a, input spw_pkg::spw_data_type d);
    while (cmd_ready !== 1'b1) @(posedge clk) #2;
    cmd_valid = 1'b1;
    cmd_addr = a;
    cmd_data = d;
    q[0].push_back({1'b0, a, d});
    @(posedge clk) #2;
    cmd_valid = 1'b0;
    falls = 12'h000;
    @(posedge clk) #2;
    while (cmd_ready !== 1'b1) @(posedge clk) #2;
    check(falls, 12'(a) + 12'(d) + 12'h002);
  endtask

  // n pulses, last high lasts hold cycles; rnd gives uneven widths
  task automatic tr(input int n, input int hold, input bit rnd);
    for (int k = 1; k <= n; k++)
    begin
      drv_pin = 1'b0;
      repeat (rnd ? 1 + $urandom % 8 : 4) @(posedge clk);
      #2 drv_pin = 1'b1;
      repeat (k == n ? hold : (rnd ? 1 + $urandom % 8 : 4)) @(posedge clk);
      #2;
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (prev_pin === 1'b1 && link[0].single_wire_pin === 1'b0)
      falls = falls + 12'h001;
    prev_pin = link[0].single_wire_pin;
    if (dfl[0] === 1'b1)
      dflt_cnt = dflt_cnt + 12'h001;
    for (int i = 0; i < 2; i++)
      if (stb[i] === 1'b1 || drp[i] === 1'b1)
        take(i);
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      print_verdict();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    dev_on = 1'b1;
    cmd_valid = 1'b0;
    cmd_addr = 5'h00;
    cmd_data = 6'h00;
    drv_pin = 1'b0;
    prev_pin = 1'b0;
    falls = 12'h000;
    dflt_cnt = 12'h000;
    errors = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(53278));
    repeat (10) @(posedge clk);
    #2 rst_n = 1'b1;
    drv_pin = 1'b1;
    repeat (SU + 40) @(posedge clk) #2;
    check({11'h000, en[0]} & {11'h000, en[1]}, 12'h001);
    send(5'h00, 6'h00);
    send(5'h1F, 6'h3F);
    send(5'h05, 6'h03);
    repeat (6) send(5'($urandom), 6'($urandom));
    // clock enable low freezes the idle timers
    ce = 1'b0;
    repeat (STBY + 20) @(posedge clk) #2;
    check({11'h000, sby[0]}, 12'h000);
    ce = 1'b1;
    repeat (STBY + 20) @(posedge clk) #2;
    check({11'h000, sby[0]}, 12'h001);
    send(5'h09, 6'h11);
    dev_on = 1'b0;
    repeat (SD + 10) @(posedge clk) #2;
    check({11'h000, en[0]}, 12'h000);
    check(dflt_cnt, 12'h001);
    dev_on = 1'b1;
    send(5'h03, 6'h2C);
    q[1] = '{12'h0C7, 12'h101, 12'h800, 12'h000, 12'h800, 12'h045, 12'h800, 12'h083, 12'h101, 12'h042, 12'h800};
    tr(4, 60, 1'b1);
    tr(8, 250, 1'b1);
    tr(2, 20, 1'b1);
    tr(3, 60, 1'b1);
    tr(2, 50, 1'b1);
    tr(33, 60, 1'b0);
    tr(1, 60, 1'b0);
    tr(1, 50, 1'b0);
    tr(3, 90, 1'b0);
    tr(2, 60, 1'b0);
    tr(6, 50, 1'b0);
    tr(1, 60, 1'b0);
    tr(65, 50, 1'b0);
    tr(3, 60, 1'b0);
    tr(4, 50, 1'b0);
    tr(5, 60, 1'b0);
    tr(2, 50, 1'b0);
    tr(2, 45, 1'b0);
    tr(3, 60, 1'b0);
    tr(2, 50, 1'b0);
    repeat (100) @(posedge clk) #2;
    check(12'(q[0].size()) | 12'(q[1].size()), 12'h000);
    print_verdict();
  end
endmodule
